// >>> hdl/lpgcd_pkg.sv
package lpgcd_pkg;

  // ------------------------------------------------------------
  // Command byte encodings
  // ------------------------------------------------------------
  localparam logic [4:0] CMD_STATIC_LOW = 5'h0c;
  localparam logic [4:0] CMD_STATIC_HIGH = 5'h0d;
  localparam logic [4:0] CMD_PWM_POINTER = 5'h0e;
  localparam logic [1:0] CMD_DISPLAY_POINTER = 2'h2;

  // ------------------------------------------------------------
  // Control byte select field
  // ------------------------------------------------------------
  localparam int SEL_HI = 5;
  localparam int SEL_LO = 4;
  localparam logic [1:0] SEL_COMMAND = 2'h0;
  localparam logic [1:0] SEL_RAM = 2'h1;
  localparam logic [1:0] SEL_PWM = 2'h2;

  // ------------------------------------------------------------
  // Multiplex and bias settings
  // ------------------------------------------------------------
  localparam logic [1:0] MUX_8 = 2'h0;
  localparam logic [1:0] MUX_6 = 2'h1;
  localparam logic [1:0] MUX_4 = 2'h2;
  localparam logic [1:0] BIAS_HALF = 2'h2;
  localparam logic [5:0] DP_MAX_MUX8 = 6'h27;
  localparam logic [5:0] DP_MAX_MUX6 = 6'h29;
  localparam logic [5:0] DP_MAX_MUX4 = 6'h2b;

  // ------------------------------------------------------------
  // Sizes and reset values
  // ------------------------------------------------------------
  localparam int RAM_WORDS = 44;
  localparam int PWM_CHANNELS = 6;
  localparam int GP_COUNT = 6;
  localparam int FIFO_WORDS = 8;
  localparam logic [2:0] PP_MAX = 3'h5;
  localparam logic [5:0] STATIC_RESET = 6'h00;
  localparam logic [5:0] DP_RESET = 6'h00;
  localparam logic [2:0] PP_RESET = 3'h0;
  localparam logic [6:0] PWM_RESET = 7'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] data;
  } lpgcd_rx_byte_type;

  typedef enum logic [1:0] {FR_IDLE, FR_CTRL, FR_DATA} lpgcd_frame_type;
  typedef enum logic {DR_READY, DR_HOLD} lpgcd_drain_type;

endpackage

// >>> hdl/lpgcd_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Command 01100 loads static levels of outputs 2..0
// - Command 01101 loads static levels of outputs 5..3
// - Pin shows static bit only when static-configured
// - All static level bits reset to zero
// - Command 10xxxxxx loads the display RAM pointer
// - Valid display pointer range follows multiplex mode
// - Display pointer increments after each RAM write
// - Invalid display pointer discards RAM writes
// - Command 01110 loads the PWM channel pointer
// - PWM pointer above five discards PWM writes
// - Select 01 writes full byte into RAM
// - Select 10 writes 7-bit level to PWM
// - Reset disables display, sets general output levels to zero
// - Reset disables all six general outputs
// - Reset selects 1:8 multiplex with half bias
// - Reset clears display and PWM pointers
// - Reset clears all six PWM levels
// - Display RAM is never initialised by reset
// - Oscillator runs, clock pin undriven after reset
// - Reset restores configuration, keeps RAM contents

// --------------------------------------------------------------
// Byte FIFO
// --------------------------------------------------------------
module lpgcd_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire do_push = in_valid && in_ready;
  wire do_pop = out_valid && out_ready;
  wire ptr_same = (wr_q[AW-1:0] == rd_q[AW-1:0]);

  assign in_ready = !(ptr_same && (wr_q[AW] != rd_q[AW]));
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem[rd_q[AW-1:0]];

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(do_push);
      rd_q <= rd_q + (AW+1)'(do_pop);
    end
  end
endmodule

// --------------------------------------------------------------
// Command decoder top
// --------------------------------------------------------------
module lpgcd_top
  import lpgcd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_clk_pin,
  input wire logic link_data_pin,
  input wire logic link_sel_n_pin,
  input wire logic [GP_COUNT-1:0] gpo_static_en,
  input wire logic [1:0] mux_mode_cfg,
  input wire logic display_on_req,
  input wire logic [5:0] ram_rd_addr,
  output logic [GP_COUNT-1:0] general_out_pin_q,
  output logic [GP_COUNT-1:0] general_out_oe_n_q,
  output logic [PWM_CHANNELS-1:0][6:0] pwm_level_q,
  output logic [7:0] ram_rd_data_q,
  output logic [5:0] display_ram_pointer_q,
  output logic [2:0] pwm_channel_pointer_q,
  output logic display_en_q,
  output logic [1:0] mux_mode_q,
  output logic [1:0] bias_q,
  output logic osc_run_q,
  output logic osc_clock_pin_q,
  output logic osc_clock_pin_oe_n_q,
  output logic overrun_q
);

  // ------------------------------------------------------------
  // Link pin sampling
  // ------------------------------------------------------------
  logic [2:0] clk_s_q;
  logic [2:0] dat_s_q;
  logic [2:0] sel_s_q;
  logic clk_lvl_q;
  logic sel_lvl_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clk_s_q <= 3'h0;
      dat_s_q <= 3'h0;
      sel_s_q <= 3'h7;
    end else begin
      clk_s_q <= {clk_s_q[1:0], link_clk_pin};
      dat_s_q <= {dat_s_q[1:0], link_data_pin};
      sel_s_q <= {sel_s_q[1:0], link_sel_n_pin};
    end
  end

  wire clk_agree = (clk_s_q[1] == clk_s_q[2]);
  wire sel_agree = (sel_s_q[1] == sel_s_q[2]);
  wire clk_rise = clk_agree && clk_s_q[2] && !clk_lvl_q;
  wire sel_lvl_d = sel_agree ? sel_s_q[2] : sel_lvl_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clk_lvl_q <= 1'b0;
      sel_lvl_q <= 1'b1;
    end else begin
      clk_lvl_q <= clk_agree ? clk_s_q[2] : clk_lvl_q;
      sel_lvl_q <= sel_lvl_d;
    end
  end

  // ------------------------------------------------------------
  // Byte assembly and framing
  // ------------------------------------------------------------
  lpgcd_frame_type frame_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [1:0] sel_field_q;
  logic push_q;
  lpgcd_rx_byte_type push_data_q;
  logic fifo_in_ready;

  wire bit_take = !sel_lvl_q && clk_rise;
  wire byte_done = bit_take && (bit_cnt_q == BIT_LAST);
  wire [7:0] byte_now = {shift_q, dat_s_q[2]};
  wire frame_start = sel_lvl_q && !sel_lvl_d;

  always_ff @(posedge clock) begin
    if (!rst_n || sel_lvl_q) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
    end else if (bit_take) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= byte_now[6:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      frame_q <= FR_IDLE;
      sel_field_q <= SEL_COMMAND;
    end else begin
      unique case (frame_q)
        FR_IDLE: begin
          if (frame_start) begin
            frame_q <= FR_CTRL;
          end
        end
        FR_CTRL: begin
          if (sel_lvl_q) begin
            frame_q <= FR_IDLE;
          end else if (byte_done) begin
            sel_field_q <= byte_now[SEL_HI:SEL_LO];
            frame_q <= FR_DATA;
          end
        end
        FR_DATA: begin
          if (sel_lvl_q) begin
            frame_q <= FR_IDLE;
          end
        end
      endcase
    end
  end

  wire push_d = byte_done && (frame_q == FR_DATA);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      push_q <= 1'b0;
      push_data_q <= '0;
    end else begin
      push_q <= push_d;
      push_data_q <= push_d ? lpgcd_rx_byte_type'{sel: sel_field_q, data: byte_now} : push_data_q;
    end
  end

  // Byte lost when FIFO is full; the set takes priority over the clear
  wire overrun_set = push_q && !fifo_in_ready;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= overrun_set || (overrun_q && !frame_start);
    end
  end

  // ------------------------------------------------------------
  // Byte FIFO and drain pacing
  // ------------------------------------------------------------
  logic fifo_out_valid;
  lpgcd_rx_byte_type fifo_out;
  lpgcd_drain_type drain_q;

  wire drain_ready = (drain_q == DR_READY);
  wire pop = fifo_out_valid && drain_ready;

  lpgcd_fifo #(
    .WIDTH($bits(lpgcd_rx_byte_type)),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(push_data_q),
    .out_valid(fifo_out_valid),
    .out_ready(drain_ready),
    .out_data(fifo_out)
  );

  // One byte every two cycles leaves a spare cycle after each write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      drain_q <= DR_READY;
    end else begin
      unique case (drain_q)
        DR_READY: drain_q <= pop ? DR_HOLD : DR_READY;
        DR_HOLD: drain_q <= DR_READY;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  logic [GP_COUNT-1:0] static_q;
  logic dp_valid_q;
  logic pp_valid_q;

  wire [7:0] d = fifo_out.data;
  wire is_cmd = pop && (fifo_out.sel == SEL_COMMAND);
  wire cmd_static_lo = is_cmd && (d[7:3] == CMD_STATIC_LOW);
  wire cmd_static_hi = is_cmd && (d[7:3] == CMD_STATIC_HIGH);
  wire cmd_pp_load = is_cmd && (d[7:3] == CMD_PWM_POINTER);
  wire cmd_dp_load = is_cmd && (d[7:6] == CMD_DISPLAY_POINTER);
  wire [5:0] dp_max = (mux_mode_q == MUX_4) ? DP_MAX_MUX4 :
                      (mux_mode_q == MUX_6) ? DP_MAX_MUX6 : DP_MAX_MUX8;
  wire ram_we = pop && (fifo_out.sel == SEL_RAM) && dp_valid_q;
  wire pwm_we = pop && (fifo_out.sel == SEL_PWM) && !d[7] && pp_valid_q;
  wire [5:0] dp_next = display_ram_pointer_q + 6'h01;
  wire [2:0] pp_next = pwm_channel_pointer_q + 3'h1;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      static_q <= STATIC_RESET;
    end else if (cmd_static_lo) begin
      static_q[2:0] <= d[2:0];
    end else if (cmd_static_hi) begin
      static_q[5:3] <= d[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      display_ram_pointer_q <= DP_RESET;
      dp_valid_q <= 1'b1;
    end else if (cmd_dp_load) begin
      display_ram_pointer_q <= d[5:0];
      dp_valid_q <= (d[5:0] <= dp_max);
    end else if (ram_we) begin
      display_ram_pointer_q <= dp_next;
      dp_valid_q <= (dp_next <= dp_max);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pwm_channel_pointer_q <= PP_RESET;
      pp_valid_q <= 1'b1;
    end else if (cmd_pp_load) begin
      pwm_channel_pointer_q <= d[2:0];
      pp_valid_q <= (d[2:0] <= PP_MAX);
    end else if (pwm_we) begin
      pwm_channel_pointer_q <= pp_next;
      pp_valid_q <= (pp_next <= PP_MAX);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pwm_level_q <= {PWM_CHANNELS{PWM_RESET}};
    end else if (pwm_we) begin
      pwm_level_q[pwm_channel_pointer_q] <= d[6:0];
    end
  end

  // ------------------------------------------------------------
  // Display RAM, left untouched by reset
  // ------------------------------------------------------------
  logic [7:0] ram [RAM_WORDS];

  always_ff @(posedge clock) begin
    if (ram_we) begin
      ram[display_ram_pointer_q] <= d;
    end
    ram_rd_data_q <= ram[ram_rd_addr];
  end

  // ------------------------------------------------------------
  // Configuration and pin outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      general_out_pin_q <= '0;
      general_out_oe_n_q <= '1;
      display_en_q <= 1'b0;
      mux_mode_q <= MUX_8;
      bias_q <= BIAS_HALF;
      osc_run_q <= 1'b1;
      osc_clock_pin_q <= 1'b0;
      osc_clock_pin_oe_n_q <= 1'b1;
    end else begin
      general_out_pin_q <= static_q & gpo_static_en;
      general_out_oe_n_q <= ~gpo_static_en;
      display_en_q <= display_on_req;
      mux_mode_q <= mux_mode_cfg;
      bias_q <= bias_q;
      osc_run_q <= 1'b1;
      osc_clock_pin_q <= 1'b0;
      osc_clock_pin_oe_n_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_STATIC_LOW: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_static_lo |=> static_q[2:0] == $past(d[2:0]))
    else $error("Low static levels not loaded");
  AST_STATIC_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_static_hi |=> static_q[5:3] == $past(d[2:0]) && static_q[2:0] == $past(static_q[2:0]))
    else $error("High static levels not loaded");
  AST_PIN_LEVEL: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 $past(gpo_static_en[0]) |-> !general_out_oe_n_q[0] && general_out_pin_q[0] == $past(static_q[0]))
    else $error("Static pin does not show its level");
  AST_RESET_CLEAR: assert property (@(posedge clock)
    !rst_n |=> static_q == STATIC_RESET && general_out_oe_n_q == '1 && pwm_level_q == '0)
    else $error("Reset values wrong");
  AST_DP_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_dp_load |=> display_ram_pointer_q == $past(d[5:0]))
    else $error("Display pointer not loaded");
  AST_DP_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
    ram_we |-> display_ram_pointer_q <= dp_max)
    else $error("RAM write outside valid range");
  AST_DP_INC: assert property (@(posedge clock) disable iff (!rst_n)
    ram_we |=> display_ram_pointer_q == $past(display_ram_pointer_q) + 6'h01)
    else $error("Display pointer not incremented");
  AST_DP_BLOCK: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_dp_load && d[5:0] > dp_max |=> !dp_valid_q ##1 !ram_we)
    else $error("RAM write after invalid pointer");
  AST_PP_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_pp_load |=> pwm_channel_pointer_q == $past(d[2:0]))
    else $error("PWM pointer not loaded");
  AST_PP_BLOCK: assert property (@(posedge clock) disable iff (!rst_n)
    pwm_we |-> pwm_channel_pointer_q <= PP_MAX)
    else $error("PWM write with invalid pointer");
  AST_PWM_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    pwm_we |=> pwm_level_q[$past(pwm_channel_pointer_q)] == $past(d[6:0])
      && pwm_channel_pointer_q == $past(pp_next))
    else $error("PWM level not stored");
  AST_RESET_CONFIG: assert property (@(posedge clock)
    !rst_n |=> mux_mode_q == MUX_8 && bias_q == BIAS_HALF && !display_en_q
      && display_ram_pointer_q == DP_RESET && pwm_channel_pointer_q == PP_RESET)
    else $error("Reset configuration wrong");
  AST_OSC_PIN: assert property (@(posedge clock)
    !rst_n |=> osc_run_q && osc_clock_pin_oe_n_q)
    else $error("Oscillator pin driven after reset");

endmodule

// >>> test/lpgcd_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Serial host driving the link pins
// ------------------------------------------------
module lpgcd_host_model
  import lpgcd_pkg::*;
(
  output logic link_clk_pin,
  output logic link_data_pin,
  output logic link_sel_n_pin
);
  initial begin
    link_clk_pin = 1'b0;
    link_data_pin = 1'b1;
    link_sel_n_pin = 1'b1;
  end

  // Data moves while the link clock is low, MSB first
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      link_data_pin = b[i];
      #400 link_clk_pin = 1'b1;
      #400 link_clk_pin = 1'b0;
    end
  endtask

  // Clock stands still outside frames
  task automatic send_frame(input logic [1:0] sel, input logic [7:0] q[$]);
    #37 link_sel_n_pin = 1'b0;
    #400 send_byte({2'h0, sel, 4'h0});
    foreach (q[i]) begin
      send_byte(q[i]);
    end
    #400 link_sel_n_pin = 1'b1;
    // Released line shows the inverse of its last bit
    link_data_pin = ~link_data_pin;
  endtask
endmodule

// >>> test/lpgcd_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module lpgcd_top_tb
  import lpgcd_pkg::*;
  ;
  logic clock;
  logic rst_n;
  logic [GP_COUNT-1:0] gpo_static_en;
  logic [1:0] mux_mode_cfg;
  logic display_on_req;
  logic [5:0] ram_rd_addr;
  wire link_clk_pin;
  wire link_data_pin;
  wire link_sel_n_pin;
  logic [GP_COUNT-1:0] general_out_pin_q;
  logic [GP_COUNT-1:0] general_out_oe_n_q;
  logic [PWM_CHANNELS-1:0][6:0] pwm_level_q;
  logic [7:0] ram_rd_data_q;
  logic [5:0] display_ram_pointer_q;
  logic [2:0] pwm_channel_pointer_q;
  logic display_en_q;
  logic [1:0] mux_mode_q;
  logic [1:0] bias_q;
  logic osc_run_q;
  logic osc_clock_pin_q;
  logic osc_clock_pin_oe_n_q;
  logic overrun_q;
  logic [7:0] q[$];
  int checks;
  int bad_count;

  lpgcd_top i_lpgcd_top (
    .clock(clock), .rst_n(rst_n), .link_clk_pin(link_clk_pin),
    .link_data_pin(link_data_pin), .link_sel_n_pin(link_sel_n_pin),
    .gpo_static_en(gpo_static_en), .mux_mode_cfg(mux_mode_cfg),
    .display_on_req(display_on_req), .ram_rd_addr(ram_rd_addr),
    .general_out_pin_q(general_out_pin_q), .general_out_oe_n_q(general_out_oe_n_q),
    .pwm_level_q(pwm_level_q), .ram_rd_data_q(ram_rd_data_q),
    .display_ram_pointer_q(display_ram_pointer_q),
    .pwm_channel_pointer_q(pwm_channel_pointer_q), .display_en_q(display_en_q),
    .mux_mode_q(mux_mode_q), .bias_q(bias_q), .osc_run_q(osc_run_q),
    .osc_clock_pin_q(osc_clock_pin_q), .osc_clock_pin_oe_n_q(osc_clock_pin_oe_n_q),
    .overrun_q(overrun_q)
  );

  lpgcd_host_model i_lpgcd_host_model (
    .link_clk_pin(link_clk_pin), .link_data_pin(link_data_pin),
    .link_sel_n_pin(link_sel_n_pin)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic stop_test();
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic frame(input logic [1:0] sel);
    i_lpgcd_host_model.send_frame(sel, q);
    repeat (24) @(negedge clock);
  endtask

  task automatic rd(input logic [5:0] a);
    ram_rd_addr = a;
    repeat (2) @(negedge clock);
  endtask

  task automatic t_reset_values();
    `CHK(general_out_pin_q, STATIC_RESET)
    `CHK(general_out_oe_n_q, 6'h3f)
    `CHK(pwm_level_q, '0)
    `CHK(display_ram_pointer_q, DP_RESET)
    `CHK(pwm_channel_pointer_q, PP_RESET)
    `CHK(display_en_q, 1'b0)
    `CHK({mux_mode_q, bias_q}, {MUX_8, BIAS_HALF})
    `CHK({osc_run_q, osc_clock_pin_q, osc_clock_pin_oe_n_q}, 3'h5)
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_static();
    gpo_static_en = 6'h3f;
    q = '{8'h65, 8'h6a};
    frame(SEL_COMMAND);
    `CHK(general_out_pin_q, 6'h15)
    `CHK(general_out_oe_n_q, 6'h00)
    q = '{8'h60};
    frame(SEL_COMMAND);
    `CHK(general_out_pin_q, 6'h10)
    gpo_static_en = 6'h0f;
    repeat (3) @(negedge clock);
    `CHK(general_out_oe_n_q, 6'h30)
    `CHK(general_out_pin_q, 6'h00)
    gpo_static_en = 6'h3f;
  endtask

  task automatic t_ram();
    mux_mode_cfg = MUX_8;
    q = '{8'ha6};
    frame(SEL_COMMAND);
    `CHK(display_ram_pointer_q, 6'h26)
    q = '{8'ha5, 8'h3c};
    frame(SEL_RAM);
    `CHK(display_ram_pointer_q, 6'h28)
    rd(6'h26);
    `CHK(ram_rd_data_q, 8'ha5)
    rd(6'h27);
    `CHK(ram_rd_data_q, 8'h3c)
    mux_mode_cfg = MUX_4;
    q = '{8'ha8};
    frame(SEL_COMMAND);
    q = '{8'h11, 8'h44, 8'h55};
    frame(SEL_RAM);
    rd(6'h28);
    `CHK(ram_rd_data_q, 8'h11)
    rd(6'h2a);
    `CHK(ram_rd_data_q, 8'h55)
    mux_mode_cfg = MUX_6;
    q = '{8'ha9};
    frame(SEL_COMMAND);
    q = '{8'h22, 8'h33};
    frame(SEL_RAM);
    `CHK(display_ram_pointer_q, 6'h2a)
    rd(6'h29);
    `CHK(ram_rd_data_q, 8'h22)
    rd(6'h2a);
    `CHK(ram_rd_data_q, 8'h55)
    mux_mode_cfg = MUX_8;
    q = '{8'ha8};
    frame(SEL_COMMAND);
    q = '{8'h99};
    frame(SEL_RAM);
    rd(6'h28);
    `CHK(ram_rd_data_q, 8'h11)
    // Display enabled only once RAM holds content
    display_on_req = 1'b1;
  endtask

  task automatic t_pwm();
    q = '{8'h74};
    frame(SEL_COMMAND);
    `CHK(pwm_channel_pointer_q, 3'h4)
    `CHK(display_en_q, 1'b1)
    q = '{8'h12, 8'h34};
    frame(SEL_PWM);
    `CHK(pwm_level_q[4], 7'h12)
    `CHK(pwm_level_q[5], 7'h34)
    q = '{8'h55};
    frame(SEL_PWM);
    `CHK(pwm_level_q[5], 7'h34)
    q = '{8'h77};
    frame(SEL_COMMAND);
    q = '{8'h66};
    frame(SEL_PWM);
    `CHK(pwm_level_q[3:0], '0)
    q = '{8'h70};
    frame(SEL_COMMAND);
    q = '{8'h81};
    frame(SEL_PWM);
    `CHK(pwm_level_q[0], 7'h00)
  endtask

  task automatic t_rst_mid();
    mux_mode_cfg = MUX_4;
    rst_n = 1'b0;
    repeat (4) @(negedge clock);
    t_reset_values();
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    rd(6'h26);
    `CHK(ram_rd_data_q, 8'ha5)
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    checks = 0;
    bad_count = 0;
    rst_n = 1'b0;
    gpo_static_en = 6'h00;
    mux_mode_cfg = MUX_8;
    display_on_req = 1'b0;
    ram_rd_addr = 6'h00;
    repeat (10) @(negedge clock);
    t_reset_values();
    rst_n = 1'b1;
    // Link stays idle until the host opens with its first command
    repeat (4) @(negedge clock);
    t_static();
    t_ram();
    t_pwm();
    t_rst_mid();
    `CHK(overrun_q, 1'b0)
    stop_test();
  end

  initial begin
    #3000000;
    bad_count++;
    stop_test();
  end
endmodule
